/* hw/pvp_pkg.sv */
// Package for the address/vector packet framer: offsets, packet codes, carrier structs.
// Assumes one 250 MHz system clock and a byte-addressed Avalon-MM register port.
package pvp_pkg;

  // Register byte offsets
  localparam logic [3:0] PVP_REG_CTRL = 4'h0;
  localparam logic [3:0] PVP_REG_STATUS = 4'h4;
  localparam logic [3:0] PVP_REG_COUNT = 4'h8;

  // Control fields and their values after reset
  localparam int PVP_CTRL_ENABLE_BIT = 0;
  localparam int PVP_CTRL_AF_END_BIT = 1;
  localparam logic PVP_CTRL_ENABLE_RST = 1'b1;

  // Packet codes
  localparam logic [7:0] PVP_ADDR_PKT_ID = 8'h01;
  localparam logic [7:0] PVP_TEMP_INDEX_BASE = 8'h80;
  localparam logic [2:0] PVP_MAX_BIT_ERRS = 3'h2;

  // Vector type codes
  localparam logic [2:0] PVP_VT_SECURE = 3'h0;
  localparam logic [2:0] PVP_VT_SHORT_INSTR = 3'h1;
  localparam logic [2:0] PVP_VT_SHORT = 3'h2;
  localparam logic [2:0] PVP_VT_NUM_STD = 3'h3;
  localparam logic [2:0] PVP_VT_NUM_SPEC = 3'h4;
  localparam logic [2:0] PVP_VT_ALPHA = 3'h5;
  localparam logic [2:0] PVP_VT_HEX = 3'h6;
  localparam logic [2:0] PVP_VT_NUM_NUMB = 3'h7;

  // Short message types
  localparam logic [1:0] PVP_ST_NUMERIC = 2'h0;
  localparam logic [1:0] PVP_ST_SOURCE = 2'h1;
  localparam logic [1:0] PVP_ST_NUMBERED = 2'h2;

  typedef enum logic [1:0] {PVP_EV_ADDR, PVP_EV_VEC, PVP_EV_MSG} pvp_kind_e;

  // One decoded event from the word decoder
  typedef struct packed {
    pvp_kind_e kind;
    logic [1:0] phase;
    logic [6:0] loc;
    logic priority_flag;
    logic long_addr_flag;
    logic tone_only_flag;
    logic temp_addr;
    logic [3:0] entry;
    logic [2:0] vtype;
    logic [2:0] bit_errs;
    logic check_fail;
    logic value_bad;
    logic [20:0] payload;
  } pvp_evt_s;

  // Temporary address assignment handed back to the decoder
  typedef struct packed {
    logic valid;
    logic [1:0] phase;
    logic [13:0] info;
  } pvp_temp_s;

endpackage

/* hw/pvp_framer.sv */
// Address-detect, vector and message packet framer with serial shift-out.
// Assumes events from the decoder logic on sys_clk; the host link pins are asynchronous.
//
// How it works
// RL1 - Priority flag copies the priority-received indication
// RL2 - Phase field is two bits, a=0 to d=3
// RL3 - Long flag set for long address entries
// RL4 - Index 0-15 for entries, 128-143 temporaries
// RL5 - Long address: one packet, index of second word
// RL6 - Tone-only flag set, no vector packet follows
// RL7 - Seven-bit vector location; host ignores if tone-only
// RL8 - Vector packet id equals its frame word position
// RL9 - Host pairs vector to address by location, phase
// RL10 - Long: first message word right after vector
// RL11 - Hex, alpha, secure, instruction vectors start all-frame
// RL12 - Host ends all-frame mode by a control write
// RL13 - Every non-tone address packet gets a vector packet
// RL14 - Vector errors set flag and block message packets
// RL15 - Host finds message words from count and start
// RL16 - Short vector layout: type 010, data, message type
// RL17 - Short vector error: over two errors or check fail
// RL18 - Short vector on long address sends next word
// RL19 - Message type selects meaning of data bits
// RL20 - Short numeric long address: five chars follow
// RL21 - Numeric vector: check bits, count, start location
// RL22 - Short instruction vector assigns temporary addresses
// RL23 - Packets are 32 bits, most significant first
// RL24 - Address packet id 1 and byte layout
// RL25 - Unused bits driven to zero
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module pvp_framer
  import pvp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire pvp_evt_s evt,
  input wire logic evt_valid,
  output logic evt_ready,
  output pvp_temp_s temp_assign,
  output logic all_frame_mode,
  input wire logic link_sclk,
  input wire logic link_sel_n,
  output logic link_sdo,
  output logic link_req,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic {LK_IDLE, LK_SHIFT} pvp_link_e;

  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic sel_m;
    logic sel_s;
    logic sel_d;
    pvp_link_e link;
    logic [31:0] shreg;
    logic [31:0] hold;
    logic hold_v;
    logic [3:0] owed;
    logic [3:0][6:0] owed_loc;
    logic [3:0] owed_long;
    logic [3:0] msg_ok;
    logic all_frame;
    pvp_temp_s temp;
    logic enable;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] sent_cnt;
    logic [15:0] drop_cnt;
  } pvp_state_s;

  localparam pvp_state_s PVP_STATE_RST = '{
    sclk_m: 1'b0, sclk_s: 1'b0, sclk_d: 1'b0,
    sel_m: 1'b1, sel_s: 1'b1, sel_d: 1'b1,
    link: LK_IDLE, shreg: 32'h0000_0000, hold: 32'h0000_0000, hold_v: 1'b0,
    owed: 4'h0, owed_loc: '0, owed_long: 4'h0, msg_ok: 4'h0,
    all_frame: 1'b0, temp: '0, enable: PVP_CTRL_ENABLE_RST,
    ack: 1'b0, rdata: 32'h0000_0000, sent_cnt: 16'h0000, drop_cnt: 16'h0000
  };

  pvp_state_s r;
  pvp_state_s next_r;

  // Unused data bits of each short message type forced to zero
  function automatic logic [13:0] pvp_short_info(input logic [13:0] info);
    logic [13:0] res;
    res = 14'h0000;
    case (info[1:0])
      PVP_ST_NUMERIC: res = info;
      PVP_ST_SOURCE: res = {9'h000, info[4:0]};
      PVP_ST_NUMBERED: res = {2'h0, info[11:0]};
      default: res = {12'h000, info[1:0]};
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic bus_req;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic accept;
  logic emit_addr;
  logic emit_vec;
  logic emit_msg;
  logic vec_err;
  logic [7:0] match_index;
  logic [1:0] ph;

  assign bus_req = avs_read | avs_write;
  assign sclk_fall = r.sclk_d & ~r.sclk_s;
  assign sel_fall = r.sel_d & ~r.sel_s;
  assign sel_rise = ~r.sel_d & r.sel_s;
  // Single packet slot: the decoder stalls until the host's select loads it into the shift register
  assign evt_ready = ~r.hold_v;
  assign accept = evt_valid & evt_ready;
  assign ph = evt.phase;

  always_comb begin
    next_r = r;
    emit_addr = 1'b0;
    emit_vec = 1'b0;
    emit_msg = 1'b0;
    next_r.temp.valid = 1'b0;
    vec_err = (evt.bit_errs > PVP_MAX_BIT_ERRS) | evt.check_fail | evt.value_bad; // RL17
    if (evt.temp_addr) begin
      match_index = PVP_TEMP_INDEX_BASE | {4'h0, evt.entry}; // RL4
    end else begin
      match_index = {4'h0, evt.entry}; // RL4
    end

    // Link pin synchronisers
    next_r.sclk_m = link_sclk;
    next_r.sclk_s = r.sclk_m;
    next_r.sclk_d = r.sclk_s;
    next_r.sel_m = link_sel_n;
    next_r.sel_s = r.sel_m;
    next_r.sel_d = r.sel_s;

    // Register port: one wait cycle; a write lands on the edge that completes it
    next_r.ack = bus_req & ~r.ack;
    if (avs_read && !r.ack) begin
      if (avs_address == PVP_REG_CTRL) begin
        next_r.rdata = {31'h0000_0000, r.enable};
      end else if (avs_address == PVP_REG_STATUS) begin
        next_r.rdata = {16'h0000, r.msg_ok, r.owed, 6'h00, r.hold_v, r.all_frame};
      end else if (avs_address == PVP_REG_COUNT) begin
        next_r.rdata = {r.drop_cnt, r.sent_cnt};
      end else begin
        next_r.rdata = 32'h0000_0000;
      end
    end else if (avs_write && r.ack && avs_address == PVP_REG_CTRL && avs_byteenable[0]) begin
      next_r.enable = avs_writedata[PVP_CTRL_ENABLE_BIT];
      if (avs_writedata[PVP_CTRL_AF_END_BIT]) begin
        next_r.all_frame = 1'b0; // RL12
      end
    end

    // Serial side: load at select, shift on each falling clock edge
    case (r.link)
      LK_IDLE: begin
        if (sel_fall) begin
          next_r.link = LK_SHIFT;
          next_r.shreg = r.hold_v ? r.hold : 32'h0000_0000;
          if (r.hold_v) begin
            next_r.hold_v = 1'b0;
            next_r.sent_cnt = r.sent_cnt + 16'h0001;
          end
        end
      end
      LK_SHIFT: begin
        if (sel_rise) begin
          next_r.link = LK_IDLE;
        end else if (sclk_fall) begin
          next_r.shreg = {r.shreg[30:0], 1'b0}; // RL23
        end
      end
      default: next_r.link = LK_IDLE;
    endcase

    // Packet formation; an event set here wins over a clear above
    if (accept) begin
      if (!r.enable) begin
        next_r.drop_cnt = r.drop_cnt + 16'h0001;
      end else begin
        case (evt.kind)
          PVP_EV_ADDR: begin
            // First word of a long pair is swallowed; the odd partner reports
            if (evt.long_addr_flag && !evt.entry[0]) begin // RL5
              next_r.drop_cnt = r.drop_cnt + 16'h0001;
            end else begin
              emit_addr = 1'b1;
              next_r.hold = {PVP_ADDR_PKT_ID, evt.priority_flag, ph, // RL1 RL2 RL24
                evt.long_addr_flag, 4'h0, match_index, // RL3 RL25
                evt.tone_only_flag, evt.loc}; // RL6 RL7
              next_r.hold_v = 1'b1;
              next_r.msg_ok[ph] = 1'b0;
              next_r.owed[ph] = ~evt.tone_only_flag; // RL6 RL13
              next_r.owed_loc[ph] = evt.loc;
              next_r.owed_long[ph] = evt.long_addr_flag;
            end
          end
          PVP_EV_VEC: begin
            // Vectors with no owed address (tone-only or stray) are dropped
            if (r.owed[ph] && r.owed_loc[ph] == evt.loc) begin // RL9 RL13
              emit_vec = 1'b1;
              next_r.owed[ph] = 1'b0;
              next_r.hold_v = 1'b1;
              if (evt.vtype == PVP_VT_SHORT) begin
                next_r.hold = {1'b0, evt.loc, vec_err, ph, 2'h0, evt.vtype, // RL8 RL16
                  2'h0, pvp_short_info(evt.payload[13:0])}; // RL19 RL25
              end else begin
                next_r.hold = {1'b0, evt.loc, vec_err, ph, 2'h0, evt.vtype, // RL8
                  2'h0, evt.payload[13:0]}; // RL21
              end
              case (evt.vtype)
                PVP_VT_SHORT: next_r.msg_ok[ph] = ~vec_err & r.owed_long[ph]; // RL18 RL20
                PVP_VT_SHORT_INSTR: next_r.msg_ok[ph] = 1'b0;
                default: next_r.msg_ok[ph] = ~vec_err; // RL14 RL10
              endcase
              if (!vec_err) begin
                if (evt.vtype == PVP_VT_SECURE || evt.vtype == PVP_VT_ALPHA ||
                    evt.vtype == PVP_VT_HEX || evt.vtype == PVP_VT_SHORT_INSTR) begin
                  next_r.all_frame = 1'b1; // RL11
                end
                if (evt.vtype == PVP_VT_SHORT_INSTR) begin
                  next_r.temp.valid = 1'b1; // RL22
                  next_r.temp.phase = ph;
                  next_r.temp.info = evt.payload[13:0];
                end
              end
            end else begin
              next_r.drop_cnt = r.drop_cnt + 16'h0001;
            end
          end
          default: begin
            // Message words pass only behind a clean vector on that phase
            if (r.msg_ok[ph]) begin // RL14
              emit_msg = 1'b1;
              next_r.hold_v = 1'b1;
              next_r.hold = {1'b0, evt.loc, vec_err, ph, evt.payload};
            end else begin
              next_r.drop_cnt = r.drop_cnt + 16'h0001;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r <= PVP_STATE_RST;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign temp_assign = r.temp;
  assign all_frame_mode = r.all_frame;
  assign link_sdo = r.shreg[31]; // RL23
  assign link_req = r.hold_v;
  assign avs_readdata = r.rdata;
  assign avs_waitrequest = bus_req & ~r.ack;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence seq_frame_start;
    r.link == LK_IDLE && sel_fall && r.hold_v;
  endsequence

  sequence seq_vec_taken;
    accept && r.enable && evt.kind == PVP_EV_VEC && r.owed[ph] && r.owed_loc[ph] == evt.loc;
  endsequence

  sequence seq_instr_taken;
    seq_vec_taken ##0 (!vec_err && evt.vtype == PVP_VT_SHORT_INSTR);
  endsequence

  sequence seq_msg_refused;
    accept && r.enable && evt.kind == PVP_EV_MSG && !r.msg_ok[ph];
  endsequence

  chk_addr_layout: assert property ( // RL24
    emit_addr |=> r.hold_v && r.hold[31:24] == PVP_ADDR_PKT_ID && r.hold[19:16] == 4'h0 &&
      r.hold[22:21] == $past(evt.phase) && r.hold[23] == $past(evt.priority_flag))
    else $error("address packet layout wrong");

  chk_index_range: assert property ( // RL4
    emit_addr |=> r.hold[15:8] < 8'h10 || (r.hold[15:8] >= 8'h80 && r.hold[15:8] < 8'h90))
    else $error("match index out of range");

  chk_long_second: assert property ( // RL5
    emit_addr && evt.long_addr_flag |=> r.hold[8] && r.hold[20])
    else $error("long address packet not on second word");

  chk_tone_no_vec: assert property ( // RL6
    emit_addr && evt.tone_only_flag |=> !r.owed[$past(evt.phase)] && r.hold[7])
    else $error("tone-only address still owes a vector");

  chk_vec_id: assert property ( // RL8
    seq_vec_taken |=> r.hold[31] == 1'b0 && r.hold[30:24] == $past(evt.loc) &&
      r.hold[22:21] == $past(evt.phase))
    else $error("vector packet id does not match location");

  chk_err_blocks_msg: assert property ( // RL14
    seq_vec_taken ##0 vec_err |=> !r.msg_ok[$past(evt.phase)] && r.hold[23])
    else $error("errored vector let message words through");

  chk_all_frame_set: assert property ( // RL11
    seq_vec_taken ##0 (!vec_err && (evt.vtype == PVP_VT_HEX || evt.vtype == PVP_VT_ALPHA))
      |=> all_frame_mode [*2])
    else $error("all-frame mode not entered");

  chk_short_layout: assert property ( // RL16
    seq_vec_taken ##0 evt.vtype == PVP_VT_SHORT |=> r.hold[18:16] == PVP_VT_SHORT &&
      r.hold[15:14] == 2'h0 && r.hold[20:19] == 2'h0)
    else $error("short vector layout wrong");

  chk_serial_msb: assert property ( // RL23
    seq_frame_start |=> link_sdo == $past(r.hold[31]) && !link_req)
    else $error("packet not shifted out most significant bit first");

  chk_long_flag: assert property ( // RL3
    emit_addr |=> r.hold[20] == $past(evt.long_addr_flag) &&
      r.hold[7] == $past(evt.tone_only_flag))
    else $error("long or tone flag not copied into address packet");

  chk_vec_clears_owed: assert property ( // RL13
    emit_vec |=> r.hold_v && !r.owed[$past(evt.phase)])
    else $error("vector packet left its address owing");

  chk_err_flag: assert property ( // RL17
    seq_vec_taken ##0 (evt.bit_errs > PVP_MAX_BIT_ERRS || evt.check_fail) |=> r.hold[23])
    else $error("vector error flag not set");

  chk_short_long_msg: assert property ( // RL18
    seq_vec_taken ##0 (evt.vtype == PVP_VT_SHORT && !vec_err && r.owed_long[ph])
      |=> r.msg_ok[$past(evt.phase)])
    else $error("short vector on long address blocks its message word");

  chk_msg_layout: assert property ( // RL10
    emit_msg |=> r.hold_v && r.hold[31] == 1'b0 && r.hold[30:24] == $past(evt.loc) &&
      r.hold[22:21] == $past(evt.phase))
    else $error("message packet position or phase wrong");

  chk_msg_blocked: assert property ( // RL14
    seq_msg_refused |=> !r.hold_v)
    else $error("message word sent without a clean vector");

  chk_temp_pulse: assert property ( // RL22
    seq_instr_taken |=> (temp_assign.valid && temp_assign.phase == $past(evt.phase))
      ##1 !temp_assign.valid)
    else $error("temporary address assignment not a single pulse");

  chk_all_frame_instr: assert property ( // RL11
    seq_vec_taken ##0 (!vec_err && (evt.vtype == PVP_VT_SECURE ||
      evt.vtype == PVP_VT_SHORT_INSTR)) |=> all_frame_mode)
    else $error("all-frame mode not entered for secure or instruction vector");

endmodule

`default_nettype wire

/* testbench/pvp_host_model.sv */
// Host end of the serial packet link: selects, clocks and shifts in 32 bits.
// Assumes the framer moves a bit on each falling link clock; the host samples on rising.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module pvp_host_model (
  input wire logic link_req,
  input wire logic link_sdo,
  input wire logic poll,
  output logic link_sclk,
  output logic link_sel_n,
  output logic [31:0] rx_word,
  output int rx_count
);
  logic [31:0] sh;

  // Clock idles low outside frames; odd start offset keeps edges off sys_clk only for a frame that had to wait for link_req or poll
  initial begin
    link_sclk = 1'b0;
    link_sel_n = 1'b1;
    rx_word = 32'h0;
    rx_count = 0;
    sh = 32'h0;
    forever begin
      wait (link_req === 1'b1 || poll === 1'b1);
      #31;
      link_sel_n = 1'b0;
      #48;
      repeat (32) begin
        link_sclk = 1'b1;
        sh = {sh[30:0], link_sdo};
        #24;
        link_sclk = 1'b0;
        #24;
      end
      rx_word = sh;
      rx_count++;
      link_sel_n = 1'b1;
      #48;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_pvp_framer.sv */
// Bench for the packet framer: decoder events in, packets out through the host model.
// Assumes the register port answers after a wait state; the tasks still wait for it.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module tb_pvp_framer
  import pvp_pkg::*;
;
  logic sys_clk, reset_n, evt_valid, evt_ready, poll, all_frame_mode;
  logic link_sclk, link_sel_n, link_sdo, link_req;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, rx_word;
  logic [2:0] vts [5];
  pvp_evt_s evt, e;
  pvp_temp_s temp_assign;
  int num_errors, compares, seen, exp_drop, rx_count;

  pvp_framer u_pvp_framer (.sys_clk(sys_clk), .reset_n(reset_n), .evt(evt),
    .evt_valid(evt_valid), .evt_ready(evt_ready), .temp_assign(temp_assign),
    .all_frame_mode(all_frame_mode), .link_sclk(link_sclk), .link_sel_n(link_sel_n),
    .link_sdo(link_sdo), .link_req(link_req), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  pvp_host_model u_pvp_host_model (.link_req(link_req), .link_sdo(link_sdo), .poll(poll),
    .link_sclk(link_sclk), .link_sel_n(link_sel_n), .rx_word(rx_word), .rx_count(rx_count));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tmo(input int i);
    if (i >= 1000) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 1000);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    tmo(i);
  endtask

  // Expected packet worked out from the event fields alone
  function automatic logic [31:0] pk(input pvp_evt_s x);
    logic er;
    logic [13:0] p;
    logic [7:0] ix;
    er = x.bit_errs > PVP_MAX_BIT_ERRS || x.check_fail || x.value_bad;
    p = x.payload[13:0];
    ix = x.temp_addr ? PVP_TEMP_INDEX_BASE | 8'(x.entry) : 8'(x.entry);
    if (x.vtype == PVP_VT_SHORT && p[1:0] == PVP_ST_SOURCE) p[13:5] = 9'h000;
    if (x.vtype == PVP_VT_SHORT && p[1:0] == PVP_ST_NUMBERED) p[13:12] = 2'h0;
    if (x.vtype == PVP_VT_SHORT && p[1:0] == 2'h3) p[13:2] = 12'h000;
    case (x.kind)
      PVP_EV_ADDR: pk = {PVP_ADDR_PKT_ID, x.priority_flag, x.phase, x.long_addr_flag, 4'h0,
        ix, x.tone_only_flag, x.loc};
      PVP_EV_VEC: pk = {1'b0, x.loc, er, x.phase, 2'h0, x.vtype, 2'h0, p};
      default: pk = {1'b0, x.loc, er, x.phase, x.payload};
    endcase
  endfunction

  function automatic pvp_evt_s mk(input pvp_kind_e k, input logic [1:0] p, input logic [6:0] l);
    mk = '0;
    mk.kind = k;
    mk.phase = p;
    mk.loc = l;
  endfunction

  task automatic pkt(input logic [31:0] x);
    int i;
    for (i = 0; i < 1000 && rx_count == seen; i++) @(posedge sys_clk);
    tmo(i);
    seen++;
    chk(rx_word, x);
  endtask

  // A dropped event must not produce a frame; a stray one shifts every later compare
  task automatic send(input logic drop);
    int i;
    @(posedge sys_clk);
    evt <= e;
    evt_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (evt_ready !== 1'b1 && i < 1000);
    evt_valid <= 1'b0;
    tmo(i);
    if (drop) begin
      exp_drop++;
      @(posedge sys_clk);
      chk(32'(link_req), 32'h0);
    end else begin
      pkt(pk(e));
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    conclude();
  end

  initial begin
    int i;
    {evt, e, evt_valid, poll, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {num_errors, compares, seen, exp_drop} = '0;
    vts = '{PVP_VT_SECURE, PVP_VT_ALPHA, PVP_VT_HEX, PVP_VT_SHORT_INSTR, PVP_VT_HEX};
    reset_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      av(1'b0, 4'(4 * i), 32'h0);
      chk(rd, i == 0 ? {31'h0, PVP_CTRL_ENABLE_RST} : 32'h0);
    end
    // Every phase, index boundaries, all four short message types
    for (i = 0; i < 4; i++) begin
      e = mk(PVP_EV_ADDR, 2'(i), i == 3 ? 7'h57 : 7'h02 + 7'(i) * 7'h1C);
      e.priority_flag = i[0];
      e.entry = 4'(i) * 4'h5;
      e.temp_addr = i[1];
      send(1'b0);
      e.kind = PVP_EV_VEC;
      e.vtype = PVP_VT_SHORT;
      e.payload = {7'h00, 12'hFFF, 2'(i)};
      send(1'b0);
    end
    // Long addresses: numeric then short vector, each with its trailing word
    for (i = 0; i < 2; i++) begin
      e = mk(PVP_EV_ADDR, 2'(i + 1), 7'h10);
      e.long_addr_flag = 1'b1;
      e.entry = 4'(i) * 4'h2 + 4'h2;
      send(1'b1);
      e.entry = e.entry + 4'h1;
      send(1'b0);
      e = mk(PVP_EV_VEC, 2'(i + 1), 7'h10);
      e.vtype = i == 0 ? PVP_VT_NUM_STD : PVP_VT_SHORT;
      e.payload = i == 0 ? {7'h00, 4'hA, 3'h5, 7'h12} : {7'h00, 12'h123, PVP_ST_NUMERIC};
      send(1'b0);
      e = mk(PVP_EV_MSG, 2'(i + 1), 7'h11);
      e.payload = 21'h1ABCDE;
      send(1'b0);
    end
    e = mk(PVP_EV_ADDR, 2'h3, 7'h20);
    e.tone_only_flag = 1'b1;
    e.entry = 4'h7;
    send(1'b0);
    e.kind = PVP_EV_VEC;
    e.vtype = PVP_VT_SHORT;
    send(1'b1);
    // Error flag causes; two bit errors is still clean
    for (i = 0; i < 4; i++) begin
      e = mk(PVP_EV_ADDR, 2'h0, 7'h1E);
      e.entry = 4'h1;
      send(1'b0);
      e = mk(PVP_EV_VEC, 2'h0, 7'h1E);
      e.vtype = PVP_VT_NUM_SPEC;
      e.bit_errs = i == 0 ? 3'h3 : 3'h2;
      e.check_fail = i == 2;
      e.value_bad = i == 3;
      send(1'b0);
      e = mk(PVP_EV_MSG, 2'h0, 7'h1F);
      if (i < 2) send(i == 0);
    end
    // All-frame entry per vector kind, then host ends it
    for (i = 0; i < 5; i++) begin
      e = mk(PVP_EV_ADDR, 2'h2, 7'h40);
      e.entry = 4'h9;
      send(1'b0);
      e = mk(PVP_EV_VEC, 2'h2, 7'h40);
      e.vtype = vts[i];
      e.bit_errs = i == 4 ? 3'h3 : 3'h0;
      e.payload = 21'h001234;
      send(1'b0);
      chk(32'(all_frame_mode), 32'(i < 4));
      if (i == 3) chk(32'({temp_assign.phase, temp_assign.info}), 32'h9234);
      av(1'b1, PVP_REG_CTRL, 32'h3);
      av(1'b0, PVP_REG_STATUS, 32'h0);
      chk(32'({rd[0], all_frame_mode}), 32'h0);
    end
    av(1'b1, PVP_REG_CTRL, 32'h0);
    e = mk(PVP_EV_ADDR, 2'h1, 7'h05);
    send(1'b1);
    av(1'b1, PVP_REG_CTRL, 32'h1);
    poll <= 1'b1;
    pkt(32'h0);
    poll <= 1'b0;
    av(1'b0, PVP_REG_COUNT, 32'h0);
    // The idle poll frame carried no packet, so it is not in the sent count
    chk(rd, {16'(exp_drop), 16'(seen - 1)});
    conclude();
  end
endmodule
`default_nettype wire
